// >>> rtl/pin_timer_consts.vh
/*
 * register offsets, field positions, reset values and encodings of the
 * timer output pin block.
 * assumes a 32-bit classic wishbone slave with word addressing by byte.
 */
`ifndef PIN_TIMER_CONSTS_VH
`define PIN_TIMER_CONSTS_VH

// register byte offsets
`define OFS_START 8'h00
`define OFS_MUX 8'h04
`define OFS_STATUS 8'h08
`define OFS_CH_BASE 8'h10
`define OFS_CH_STRIDE 8'h10
`define OFS_MODE 4'h0
`define OFS_IOCTL 4'h4
`define OFS_CMP_A 4'h8
`define OFS_CMP_B 4'hc

// timer mode register fields
`define MODE_NORMAL 2'h0
`define MODE_PWM_MODE_ONE 2'h2
`define MODE_PWM_MODE_TWO 2'h3
`define MODE_BUF_C_BIT 2
`define MODE_BUF_D_BIT 3
`define MODE_RESET 4'h0

// io control register: per pin, bit0 initial level, bits 2:1 match action
`define IO_INIT_BIT 0
`define IO_ACT_LO 1
`define IO_ACT_HI 2
`define ACT_NONE 2'h0
`define ACT_LOW 2'h1
`define ACT_HIGH 2'h2
`define ACT_TOGGLE 2'h3
`define IO_PIN_WIDTH 4
`define IO_RESET 16'h0000

`define CNT_RESET 16'h0000

`endif

// >>> rtl/pin_level_cell.v
/*
 * one timer output pin: holds the level, presets it on a control write,
 * changes it on compare match.
 * assumes preset and match arrive as one-cycle pulses on clk_i.
 */
`include "pin_timer_consts.vh"

module pin_level_cell (
    input wire clk_i,
    input wire rst_i,
    input wire standby_i,
    input wire preset_i,
    input wire preset_level_i,
    input wire match_i,
    input wire [1:0] action_i,
    output reg level_o
);

    always @(posedge clk_i) begin
        if (rst_i || standby_i) begin
            level_o <= 1'b0;
        end else if (preset_i) begin
            level_o <= preset_level_i;
        end else if (match_i) begin
            // a preset in the same cycle wins, so software sees its level
            case (action_i)
                `ACT_LOW: level_o <= 1'b0;
                `ACT_HIGH: level_o <= 1'b1;
                `ACT_TOGGLE: level_o <= ~level_o;
                default: level_o <= level_o;
            endcase
        end
    end

endmodule // pin_level_cell

// >>> rtl/chan_counter.v
/*
 * one channel's up-counter with two compare registers.
 * assumes the start bit comes from logic on clk_i; the counter clears when
 * it reaches the period value.
 */
`include "pin_timer_consts.vh"

module chan_counter #(
    parameter WIDTH = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire run_i,
    input wire [WIDTH-1:0] cmp_a_i,
    input wire [WIDTH-1:0] cmp_b_i,
    input wire clear_on_b_i,
    output reg [WIDTH-1:0] count_o,
    output reg match_a_o,
    output reg match_b_o
);

    wire hit_a;
    wire hit_b;
    wire wrap;

    assign hit_a = run_i && (count_o == cmp_a_i);
    assign hit_b = run_i && (count_o == cmp_b_i);
    assign wrap = clear_on_b_i ? hit_b : hit_a;

    always @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= {WIDTH{1'b0}};
            match_a_o <= 1'b0;
            match_b_o <= 1'b0;
        end else begin
            match_a_o <= hit_a;
            match_b_o <= hit_b;
            if (run_i) begin
                count_o <= wrap ? {WIDTH{1'b0}} : count_o + 1'b1;
            end
        end
    end

endmodule // chan_counter

// >>> rtl/timer_output_pin_init.v
/*
 * output pin handling of a three-channel 16-bit pulse timer: mode, io
 * control and start registers over classic wishbone, per-pin levels, and
 * the pin function mux stage that hands levels to the ports.
 * assumes one clock, synchronous reset, and a single-cycle wishbone master.
 */
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
// Operation
// - timer levels low after reset, standby
// - pins high impedance until mux selects
// - mux select shows current timer level
// - normal, pwm one, pwm two per channel
// - mode register resets to normal
// - io control write presets selected pins
// - pwm one leaves b pin untouched
// - pwm two leaves period pin untouched
// - normal/pwm two buffers block c,d pins
// - pwm one buffer blocks c pin
// - start bit runs, clear stops counting
// - compare match drives configured level
`include "pin_timer_consts.vh"

module timer_output_pin_init #(
    parameter CHANNELS = 3,
    parameter WIDTH = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire standby_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output reg [4*CHANNELS-1:0] pin_o,
    output reg [4*CHANNELS-1:0] pin_oe_n_o
);

    localparam PINS = 4 * CHANNELS;

    reg [CHANNELS-1:0] start;
    reg [PINS-1:0] mux_timer;
    reg [PINS-1:0] port_level;
    reg [PINS-1:0] port_drive;
    reg [3:0] mode [0:CHANNELS-1];
    reg [15:0] ioctl [0:CHANNELS-1];
    reg [WIDTH-1:0] cmp_a [0:CHANNELS-1];
    reg [WIDTH-1:0] cmp_b [0:CHANNELS-1];
    reg [31:0] next_dat;
    reg sync_standby_0;
    reg sync_standby;

    wire [PINS-1:0] level;
    wire [PINS-1:0] preset;
    wire [PINS-1:0] match;
    wire access;
    wire wr;
    wire [1:0] chan_idx;
    wire in_chan;

    assign access = cyc_i && stb_i && !ack_o;
    assign wr = access && we_i && (sel_i == 4'hf);
    assign in_chan = (adr_i >= `OFS_CH_BASE) &&
        (adr_i < `OFS_CH_BASE + CHANNELS * `OFS_CH_STRIDE);
    assign chan_idx = adr_i[5:4] - 2'd1;

    // standby arrives from the power controller outside this clock domain
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync_standby_0 <= 1'b0;
            sync_standby <= 1'b0;
        end else begin
            sync_standby_0 <= standby_i;
            sync_standby <= sync_standby_0;
        end
    end

    genvar c;
    genvar p;
    generate
        for (c = 0; c < CHANNELS; c = c + 1) begin : g_chan
            wire [WIDTH-1:0] count;
            wire hit_a;
            wire hit_b;
            wire [1:0] md;
            wire buf_c;
            wire buf_d;
            wire ioc_wr;
            reg [3:0] allow;

            assign md = mode[c][1:0];
            assign buf_c = mode[c][`MODE_BUF_C_BIT];
            assign buf_d = mode[c][`MODE_BUF_D_BIT];
            assign ioc_wr = wr && in_chan && (chan_idx == c) &&
                (adr_i[3:0] == `OFS_IOCTL);

            chan_counter #(
                .WIDTH(WIDTH)
            ) u_cnt (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .run_i(start[c]),
                .cmp_a_i(cmp_a[c]),
                .cmp_b_i(cmp_b[c]),
                .clear_on_b_i(1'b0),
                .count_o(count),
                .match_a_o(hit_a),
                .match_b_o(hit_b)
            );

            // pins a,b,c,d; which of them an io control write may preset
            always @* begin
                allow = 4'hf;
                case (md)
                    `MODE_PWM_MODE_ONE: begin
                        allow[1] = 1'b0;
                        if (buf_c || buf_d) begin
                            allow[2] = 1'b0;
                        end
                    end
                    `MODE_PWM_MODE_TWO: begin
                        allow[0] = 1'b0;
                        if (buf_c) allow[2] = 1'b0;
                        if (buf_d) allow[3] = 1'b0;
                    end
                    default: begin
                        if (buf_c) allow[2] = 1'b0;
                        if (buf_d) allow[3] = 1'b0;
                    end
                endcase
            end

            // a and c match on compare a, d on compare b, b on compare b except in pwm one
            assign match[4*c+0] = hit_a;
            assign match[4*c+1] = hit_b && (md != `MODE_PWM_MODE_ONE);
            assign match[4*c+2] = hit_a;
            assign match[4*c+3] = hit_b;
            assign preset[4*c+3:4*c] = ioc_wr ? allow : 4'h0;

            for (p = 0; p < 4; p = p + 1) begin : g_pin
                pin_level_cell u_pin (
                    .clk_i(clk_i),
                    .rst_i(rst_i),
                    .standby_i(sync_standby),
                    .preset_i(preset[4*c+p]),
                    .preset_level_i(dat_i[4*p+`IO_INIT_BIT]),
                    .match_i(match[4*c+p]),
                    .action_i(ioctl[c][4*p+`IO_ACT_HI:4*p+`IO_ACT_LO]),
                    .level_o(level[4*c+p])
                );
            end
        end
    endgenerate

    // read mux, address decode as an if chain
    always @* begin
        next_dat = 32'h00000000;
        if (adr_i == `OFS_START) begin
            next_dat[CHANNELS-1:0] = start;
        end else if (adr_i == `OFS_MUX) begin
            next_dat[PINS-1:0] = mux_timer;
            next_dat[16+PINS-1:16] = port_drive;
        end else if (adr_i == `OFS_STATUS) begin
            next_dat[PINS-1:0] = level;
            next_dat[16+PINS-1:16] = port_level;
        end else if (in_chan && adr_i[3:0] == `OFS_MODE) begin
            next_dat[3:0] = mode[chan_idx];
        end else if (in_chan && adr_i[3:0] == `OFS_IOCTL) begin
            next_dat[15:0] = ioctl[chan_idx];
        end else if (in_chan && adr_i[3:0] == `OFS_CMP_A) begin
            next_dat[WIDTH-1:0] = cmp_a[chan_idx];
        end else if (in_chan && adr_i[3:0] == `OFS_CMP_B) begin
            next_dat[WIDTH-1:0] = cmp_b[chan_idx];
        end
    end

    integer i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
            start <= {CHANNELS{1'b0}};
            mux_timer <= {PINS{1'b0}};
            port_level <= {PINS{1'b0}};
            port_drive <= {PINS{1'b0}};
            for (i = 0; i < CHANNELS; i = i + 1) begin
                mode[i] <= `MODE_RESET;
                ioctl[i] <= `IO_RESET;
                cmp_a[i] <= {WIDTH{1'b1}};
                cmp_b[i] <= {WIDTH{1'b1}};
            end
        end else begin
            // unmapped addresses still ack: writes drop, reads give zero
            ack_o <= access;
            dat_o <= access ? next_dat : 32'h00000000;
            if (wr) begin
                if (adr_i == `OFS_START) begin
                    start <= dat_i[CHANNELS-1:0];
                end else if (adr_i == `OFS_MUX) begin
                    mux_timer <= dat_i[PINS-1:0];
                    port_drive <= dat_i[16+PINS-1:16];
                end else if (adr_i == `OFS_STATUS) begin
                    port_level <= dat_i[16+PINS-1:16];
                end else if (in_chan && adr_i[3:0] == `OFS_MODE) begin
                    // mode 1 is unused and falls back to normal
                    mode[chan_idx] <= (dat_i[1:0] == 2'h1) ?
                        {dat_i[3:2], `MODE_NORMAL} : dat_i[3:0];
                end else if (in_chan && adr_i[3:0] == `OFS_IOCTL) begin
                    ioctl[chan_idx] <= dat_i[15:0];
                end else if (in_chan && adr_i[3:0] == `OFS_CMP_A) begin
                    cmp_a[chan_idx] <= dat_i[WIDTH-1:0];
                end else if (in_chan && adr_i[3:0] == `OFS_CMP_B) begin
                    cmp_b[chan_idx] <= dat_i[WIDTH-1:0];
                end
            end
        end
    end

    // pin stage: timer level passes through the pin register once selected, so a
    // mux switch before the preset shows the low reset level one clock later
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= {PINS{1'b0}};
            pin_oe_n_o <= {PINS{1'b1}};
        end else begin
            pin_o <= (mux_timer & level) | (~mux_timer & port_level);
            pin_oe_n_o <= ~(mux_timer | port_drive);
        end
    end

endmodule // timer_output_pin_init

// >>> dv/pin_timer_chk_sva.sv
/* port checker for the timer output pin block.
   assumes the classic wishbone slave and register map of the design. */
module pin_timer_chk #(
    parameter CHANNELS = 3
) (
    input wire clk_i,
    input wire rst_i,
    input wire standby_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire [4*CHANNELS-1:0] pin_o,
    input wire [4*CHANNELS-1:0] pin_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam N = 4*CHANNELS;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire wr = cyc_i & stb_i & we_i & !ack_o & (sel_i == 4'hf);
    reg [N-1:0] tsel;
    reg [N-1:0] pen;
    reg [N-1:0] plvl;
    // shadow of mux and port level registers, updated on the taking edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            tsel <= {N{1'b0}};
            pen <= {N{1'b0}};
            plvl <= {N{1'b0}};
        end else if (wr && adr_i == 8'h04) begin
            tsel <= dat_i[N-1:0];
            pen <= dat_i[16+N-1:16];
        end else if (wr && adr_i == 8'h08) begin
            plvl <= dat_i[16+N-1:16];
        end
    end
    property p_ack_next;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack");
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_dat_idle;
        !ack_o |-> dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data idle");
    property p_unmapped;
        cyc_i && stb_i && !we_i && !ack_o && adr_i == 8'hf0 |=> dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_rst_pins;
        $past(rst_i) |-> pin_o == {N{1'b0}} && &pin_oe_n_o;
    endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("reset pins");
    property p_oe_follow;
        !$past(rst_i) |-> pin_oe_n_o == ~$past(tsel | pen);
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("enable");
    property p_port_lvl;
        !$past(rst_i) |-> ((pin_o ^ $past(plvl)) & $past(pen & ~tsel)) == 0;
    endproperty
    a_port_lvl: assert property (p_port_lvl) else $error("port lvl");
    property p_standby;
        standby_i [*5] |-> (pin_o & tsel & ~pen) == {N{1'b0}};
    endproperty
    a_standby: assert property (p_standby) else $error("standby");
    c_write: cover property (ack_o && we_i);
    c_standby: cover property (standby_i [*5]);
    c_drive: cover property (|(pin_o & ~pin_oe_n_o));
endmodule // pin_timer_chk

bind timer_output_pin_init pin_timer_chk #(.CHANNELS(CHANNELS)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o));

// >>> dv/pin_load_model.sv
/* external load on the timer pins.
   assumes pull-downs on every pin, so a released pin reads low. */
module pin_load_model #(
    parameter N = 12
) (
    input wire [N-1:0] pin_i,
    input wire [N-1:0] oe_n_i,
    output wire [N-1:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pins fall to the pull-down, never keep the last value
    assign level_o = pin_i & ~oe_n_i;
endmodule // pin_load_model

// >>> dv/tb_timer_output_pin_init.sv
/* testbench: wishbone register sequences with expected pin levels.
   assumes the load model and the bound port checker. */
module tb_timer_output_pin_init;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, standby_i = 0, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0] adr_i = 8'h0;
    logic [7:0] b;
    logic [3:0] lv;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o;
    logic [11:0] pin_o, pin_oe_n_o, load;
    int miscompares = 0, n_checks = 0;
    logic [1:0] ch_t [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h1};
    logic [3:0] md_t [6] = '{4'h2, 4'h6, 4'h3, 4'hc, 4'hf, 4'h0};
    logic [3:0] ex_t [6] = '{4'h2, 4'h6, 4'h1, 4'hc, 4'hd, 4'h0};
    timer_output_pin_init DUT (.clk_i(clk_i), .rst_i(rst_i),
        .standby_i(standby_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o));
    pin_load_model #(.N(12)) u_load (.pin_i(pin_o), .oe_n_i(pin_oe_n_o),
        .level_o(load));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) miscompares++;
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task finish_test;
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({20'h0, pin_oe_n_o}, 32'hfff);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'hf0, 32'h0);
        chk(rd, 32'h0);
        // preset all high in normal mode, switch mode, preset the pins the mode allows low
        for (int i = 0; i < 6; i++) begin
            b = {2'b00, ch_t[i] + 2'd1, 4'h0};
            wb(1'b1, b, 32'h0);
            wb(1'b1, b + 8'h4, 32'h1111);
            wb(1'b1, b, {28'h0, md_t[i]});
            wb(1'b1, b + 8'h4, 32'h0);
            wb(1'b0, b, 32'h0);
            chk(rd, {28'h0, md_t[i]});
            wb(1'b0, 8'h08, 32'h0);
            lv = rd[4*ch_t[i] +: 4];
            chk(32'(lv[1:0]), 32'(ex_t[i][1:0]));
            chk(32'(lv[3:2]), 32'(ex_t[i][3:2]));
        end
        // the unused mode code must read back as normal
        wb(1'b1, 8'h20, 32'h1);
        wb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, 8'h10, 32'h0);
        wb(1'b1, 8'h14, 32'h3333);
        wb(1'b1, 8'h18, 32'h10);
        wb(1'b1, 8'h04, 32'hf);
        chk({28'h0, load[3:0]}, 32'hf);
        wb(1'b1, 8'h00, 32'h1);
        repeat (40) @(posedge clk_i);
        chk({30'h0, load[1:0]}, 32'h2);
        // timer deselected: pins driven to the port level register value
        wb(1'b1, 8'h08, 32'h000f0000);
        wb(1'b1, 8'h04, 32'h000f0000);
        chk({28'h0, load[3:0]}, 32'hf);
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b1, 8'h14, 32'h3333);
        wb(1'b1, 8'h04, 32'hf);
        chk({30'h0, load[1:0]}, 32'h3);
        standby_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        wb(1'b0, 8'h08, 32'h0);
        chk({20'h0, rd[11:0]}, 32'h0);
        standby_i <= 1'b0;
        finish_test();
    end
endmodule // tb_timer_output_pin_init
